// File: rtl/fcr_pkg.sv
package fcr_pkg;
// Notes on behaviour
// - Angles are unsigned 0 to 511 covering one electrical turn, wrapping naturally.
// - Three Hall levels form one 0-7 state; each level stays readable alone.
// - Each loop update samples phase currents with angle, computes Iq and Id.
// - Two independent PI regulators, flux and torque, set phase drive to track setpoints.
// - Flux setpoint is zero after reset; a loaded non-zero value is accepted.
// - Gains are integers equal to real gain times one million.
// - Gain index 1 flux, 2 torque; dual: 1-2 flux, 3-4 torque per channel.
// - The whole current loop runs once every LOOP_CYCLES clocks; the default gives one kilohertz at 40 MHz.
// - Analog or SSI sensors support a linearity capture run, applied or cleared later.
// - Angle correction, per-phase drive and sensed phase voltages are exposed for monitoring.

    localparam int                     CUR_W      = 16;
    localparam int                     ANG_W      = 9;
    localparam int                     GAIN_W     = 32;
    localparam int                     CLK_HZ     = 40000000;
    localparam int                     LOOP_HZ    = 1000;
    localparam int                     LOOP_CYC   = CLK_HZ / LOOP_HZ;
    localparam longint                 GAIN_SCALE = 64'sh00000000000f4240;
    localparam logic signed [CUR_W-1:0] DRV_MAX   = 16'sh7fff;
    localparam logic signed [63:0]     ACC_LIM    = 64'(DRV_MAX) * GAIN_SCALE * 64'(LOOP_HZ);
    localparam logic [ANG_W-1:0]       ANG_QTR    = 9'h080;
    localparam logic [5:0]             SIN_TOP    = 6'h20;
    localparam int                     TRIG_SH    = 15;
    localparam logic signed [16:0]     INV_SQRT3  = 17'sh049e7;
    localparam logic signed [16:0]     HALF_SQRT3 = 17'sh06eda;
    localparam logic [2:0]             IDX_S_FLUX = 3'h1;
    localparam logic [2:0]             IDX_S_TORQ = 3'h2;
    localparam logic [2:0]             IDX_D_OFS  = 3'h2;
    localparam int                     LIN_N      = 16;
    localparam int                     LIN_IW     = 4;
    localparam logic [2:0]             LIN_REVS   = 3'h4;
    localparam logic [ANG_W-1:0]       CAP_STEP   = 9'h004;
    localparam logic signed [CUR_W-1:0] CAP_VD    = 16'sh1000;

    // Quarter wave, 33 points so the mirror index never runs off the end
    localparam logic [14:0] SIN_TAB [0:32] = '{
        15'h0000, 15'h0648, 15'h0c8c, 15'h12c8, 15'h18f9, 15'h1f1a, 15'h2528, 15'h2b1f,
        15'h30fb, 15'h36ba, 15'h3c56, 15'h41ce, 15'h471c, 15'h4c3f, 15'h5133, 15'h55f5,
        15'h5a82, 15'h5ed7, 15'h62f1, 15'h66cf, 15'h6a6d, 15'h6dc9, 15'h70e2, 15'h73b5,
        15'h7641, 15'h7884, 15'h7a7c, 15'h7c29, 15'h7d89, 15'h7e9c, 15'h7f61, 15'h7fd8,
        15'h7fff};

    typedef enum logic [1:0] {
        SENS_HALL     = 2'h0,
        SENS_SINCOS   = 2'h1,
        SENS_RESOLVER = 2'h2,
        SENS_SSI      = 2'h3
    } fcr_sensor_t;

    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_SAMPLE = 7'h02,
        ST_PARK   = 7'h04,
        ST_PI     = 7'h08,
        ST_PIWAIT = 7'h10,
        ST_IPARK  = 7'h20,
        ST_DRIVE  = 7'h40
    } fcr_fsm_t;

    typedef struct packed {
        logic signed [CUR_W-1:0] u;
        logic signed [CUR_W-1:0] v;
        logic signed [CUR_W-1:0] w;
    } fcr_phase_t;

    typedef struct packed {
        logic              wr;
        logic              integ;
        logic [2:0]        idx;
        logic [GAIN_W-1:0] val;
    } fcr_gain_wr_t;

    typedef struct packed {
        logic [2:0] state;
        logic       a;
        logic       b;
        logic       c;
    } fcr_hall_t;

    function automatic logic signed [CUR_W-1:0] fcr_sin(input logic [ANG_W-1:0] a);
        logic [5:0]  k;
        logic [14:0] m;
        k = {1'b0, a[6:2]};
        if (a[7]) begin
            k = SIN_TOP - k;
        end
        m = SIN_TAB[k];
        fcr_sin = a[8] ? -$signed({1'b0, m}) : $signed({1'b0, m});
    endfunction : fcr_sin

    function automatic logic signed [CUR_W-1:0] fcr_sat16(input logic signed [47:0] x);
        if (x > 48'(DRV_MAX)) begin
            fcr_sat16 = DRV_MAX;
        end else if (x < -48'(DRV_MAX)) begin
            fcr_sat16 = -DRV_MAX;
        end else begin
            fcr_sat16 = x[CUR_W-1:0];
        end
    endfunction : fcr_sat16
endpackage : fcr_pkg

// File: rtl/fcr_pi.sv
module fcr_pi (
    input  wire logic                            clock_in,
    input  wire logic                            rst_in,
    input  wire logic                            step_in,
    input  wire logic                            load_kp_in,
    input  wire logic                            load_ki_in,
    input  wire logic [fcr_pkg::GAIN_W-1:0]      gain_in,
    input  wire logic signed [fcr_pkg::CUR_W:0]  err_in,
    output logic signed [fcr_pkg::CUR_W-1:0]     out_out
);
    import fcr_pkg::*;

    typedef struct packed {
        logic [GAIN_W-1:0]       kp;
        logic [GAIN_W-1:0]       ki;
        logic signed [63:0]      acc;
        logic signed [CUR_W-1:0] out;
    } fcr_pi_state_t;

    fcr_pi_state_t      st_r;
    fcr_pi_state_t      st_nxt;
    logic signed [63:0] p_term;
    logic signed [63:0] i_term;
    logic signed [63:0] sum;

    always_comb begin
        st_nxt = st_r;
        p_term = 64'(signed'({1'b0, st_r.kp})) * 64'(err_in);
        i_term = st_r.acc + 64'(signed'({1'b0, st_r.ki})) * 64'(err_in);
        if (i_term > ACC_LIM) begin
            i_term = ACC_LIM;
        end else if (i_term < -ACC_LIM) begin
            i_term = -ACC_LIM;
        end
        // gain scaling, integral term per 1 ms sample
        sum = (p_term + i_term / 64'(LOOP_HZ)) / GAIN_SCALE;
        if (load_kp_in) begin
            st_nxt.kp = gain_in;
        end
        if (load_ki_in) begin
            st_nxt.ki = gain_in;
        end
        if (step_in) begin
            st_nxt.acc = i_term;
            st_nxt.out = fcr_sat16(sum[47:0]);
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign out_out = st_r.out;

    AST_PI_SAT: assert property (@(posedge clock_in) disable iff (rst_in)
        (st_r.out <= DRV_MAX) && (st_r.out >= -DRV_MAX) && (st_r.acc <= ACC_LIM) && (st_r.acc >= -ACC_LIM))
        else $error("PI state beyond drive range");
    AST_PI_HOLD: assert property (@(posedge clock_in) disable iff (rst_in)
        !$past(step_in) |-> $stable(out_out))
        else $error("PI output moved without a step");
    AST_KP_LOAD: assert property (@(posedge clock_in) disable iff (rst_in)
        load_kp_in |=> (st_r.kp == $past(gain_in)))
        else $error("Proportional gain not stored");
endmodule : fcr_pi

// File: rtl/fcr_current_regulator.sv
module fcr_current_regulator #(
    parameter int LOOP_CYCLES = fcr_pkg::LOOP_CYC,
    parameter bit DUAL        = 1'b0,
    parameter int CHANNEL     = 1
) (
    input  wire logic                          clock_in,
    input  wire logic                          rst_in,
    input  wire fcr_pkg::fcr_phase_t           phase_i_in,
    input  wire logic [fcr_pkg::ANG_W-1:0]     angle_in,
    input  wire fcr_pkg::fcr_sensor_t          sensor_type_in,
    input  wire logic [2:0]                    hall_in,
    input  wire logic signed [fcr_pkg::CUR_W-1:0] iq_ref_in,
    input  wire logic                          id_ref_wr_in,
    input  wire logic signed [fcr_pkg::CUR_W-1:0] id_ref_in,
    input  wire fcr_pkg::fcr_gain_wr_t         gain_wr_in,
    input  wire logic                          lin_start_in,
    input  wire logic                          lin_apply_in,
    input  wire logic                          lin_clear_in,
    input  wire fcr_pkg::fcr_phase_t           sense_in,
    output fcr_pkg::fcr_phase_t                drive_out,
    output fcr_pkg::fcr_phase_t                sense_out,
    output logic signed [fcr_pkg::CUR_W-1:0]   id_out,
    output logic signed [fcr_pkg::CUR_W-1:0]   iq_out,
    output logic [fcr_pkg::ANG_W-1:0]          elec_angle_out,
    output logic [fcr_pkg::ANG_W-1:0]          angle_corr_out,
    output fcr_pkg::fcr_hall_t                 hall_out,
    output logic                               lin_busy_out,
    output logic                               lin_valid_out,
    output logic                               tick_out
);
    import fcr_pkg::*;

    typedef struct packed {
        fcr_fsm_t                    fsm;
        logic [31:0]                 cnt;
        logic signed [CUR_W-1:0]     ia;
        logic signed [CUR_W-1:0]     ib;
        logic signed [CUR_W-1:0]     id;
        logic signed [CUR_W-1:0]     iq;
        logic signed [CUR_W-1:0]     id_ref;
        logic signed [CUR_W-1:0]     va;
        logic signed [CUR_W-1:0]     vb;
        logic [ANG_W-1:0]            ang;
        fcr_phase_t                  drive;
        fcr_phase_t                  sense;
        logic [2:0]                  h1;
        logic [2:0]                  h2;
        logic [2:0]                  h3;
        fcr_hall_t                   hall;
        logic [LIN_N-1:0][ANG_W-1:0] lin;
        logic                        lin_busy;
        logic                        lin_valid;
        logic [ANG_W-1:0]            cap_ang;
        logic [2:0]                  cap_rev;
        logic [ANG_W-1:0]            corr;
        logic                        tick;
    } fcr_core_t;

    fcr_core_t               st_r;
    fcr_core_t               st_nxt;
    logic signed [CUR_W-1:0] sin_v;
    logic signed [CUR_W-1:0] cos_v;
    logic signed [CUR_W-1:0] vd_pi;
    logic signed [CUR_W-1:0] vq_pi;
    logic signed [CUR_W-1:0] vd;
    logic signed [CUR_W-1:0] vq;
    logic signed [CUR_W-1:0] beta;
    logic signed [CUR_W-1:0] half_a;
    logic signed [CUR_W:0]   err_d;
    logic signed [CUR_W:0]   err_q;
    logic signed [33:0]      t_d;
    logic signed [33:0]      t_q;
    logic signed [33:0]      t_a;
    logic signed [33:0]      t_b;
    logic signed [33:0]      t_s;
    logic [ANG_W-1:0]        cap_next;
    logic [LIN_IW-1:0]       lin_idx;
    logic [2:0]              flux_idx;
    logic [2:0]              torq_idx;
    logic                    ld_kp_d;
    logic                    ld_ki_d;
    logic                    ld_kp_q;
    logic                    ld_ki_q;
    logic                    pi_step;

    assign flux_idx = DUAL ? 3'(CHANNEL) : IDX_S_FLUX;
    assign torq_idx = DUAL ? 3'(CHANNEL) + IDX_D_OFS : IDX_S_TORQ;
    assign ld_kp_d  = gain_wr_in.wr && !gain_wr_in.integ && (gain_wr_in.idx == flux_idx);
    assign ld_ki_d  = gain_wr_in.wr && gain_wr_in.integ && (gain_wr_in.idx == flux_idx);
    assign ld_kp_q  = gain_wr_in.wr && !gain_wr_in.integ && (gain_wr_in.idx == torq_idx);
    assign ld_ki_q  = gain_wr_in.wr && gain_wr_in.integ && (gain_wr_in.idx == torq_idx);

    assign sin_v    = fcr_sin(st_r.ang);
    assign cos_v    = fcr_sin(st_r.ang + ANG_QTR);
    assign cap_next = st_r.cap_ang + CAP_STEP;
    assign lin_idx  = angle_in[ANG_W-1 -: LIN_IW];
    assign err_d    = 17'(st_r.id_ref) - 17'(st_r.id);
    assign err_q    = 17'(iq_ref_in) - 17'(st_r.iq);
    assign pi_step  = (st_r.fsm == ST_PI);

    fcr_pi u_pi_flux (
        .clock_in   (clock_in),
        .rst_in     (rst_in),
        .step_in    (pi_step),
        .load_kp_in (ld_kp_d),
        .load_ki_in (ld_ki_d),
        .gain_in    (gain_wr_in.val),
        .err_in     (err_d),
        .out_out    (vd_pi)
    );

    fcr_pi u_pi_torq (
        .clock_in   (clock_in),
        .rst_in     (rst_in),
        .step_in    (pi_step),
        .load_kp_in (ld_kp_q),
        .load_ki_in (ld_ki_q),
        .gain_in    (gain_wr_in.val),
        .err_in     (err_q),
        .out_out    (vq_pi)
    );

    always_comb begin
        st_nxt = st_r;
        // Capture run forces a rotating field; regulators keep stepping but are ignored
        vd     = st_r.lin_busy ? CAP_VD : vd_pi;
        vq     = st_r.lin_busy ? '0 : vq_pi;
        t_s    = (34'(st_r.ia) + 34'(st_r.ib) + 34'(st_r.ib)) * 34'(INV_SQRT3);
        beta   = fcr_sat16(48'(t_s >>> TRIG_SH));
        t_d    = 34'(st_r.ia) * 34'(cos_v) + 34'(beta) * 34'(sin_v);
        t_q    = 34'(beta) * 34'(cos_v) - 34'(st_r.ia) * 34'(sin_v);
        t_a    = 34'(vd) * 34'(cos_v) - 34'(vq) * 34'(sin_v);
        t_b    = 34'(vd) * 34'(sin_v) + 34'(vq) * 34'(cos_v);
        t_s    = 34'(st_r.vb) * 34'(HALF_SQRT3);
        half_a = st_r.va >>> 1;
        st_nxt.tick = 1'b0;
        // Hall sync, change taken once stages two and three agree
        st_nxt.h1 = hall_in;
        st_nxt.h2 = st_r.h1;
        st_nxt.h3 = st_r.h2;
        if (st_r.h2 == st_r.h3) begin
            st_nxt.hall = '{state: st_r.h3, a: st_r.h3[0], b: st_r.h3[1], c: st_r.h3[2]};
        end
        st_nxt.sense = sense_in;
        if (id_ref_wr_in) begin
            st_nxt.id_ref = id_ref_in;
        end
        if (lin_clear_in && !st_r.lin_busy) begin
            st_nxt.lin       = '0;
            st_nxt.lin_valid = 1'b0;
        end
        if (lin_start_in && !st_r.lin_busy && (sensor_type_in != SENS_HALL)) begin
            st_nxt.lin_busy  = 1'b1;
            st_nxt.lin_valid = 1'b0;
            st_nxt.cap_ang   = '0;
            st_nxt.cap_rev   = '0;
        end
        if (st_r.cnt == '0) begin
            st_nxt.cnt = 32'(LOOP_CYCLES - 1);
        end else begin
            st_nxt.cnt = st_r.cnt - 32'h1;
        end
        case (st_r.fsm)
            ST_IDLE: begin
                if (st_r.cnt == '0) begin
                    st_nxt.fsm = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                st_nxt.ia  = phase_i_in.u;
                st_nxt.ib  = phase_i_in.v;
                st_nxt.fsm = ST_PARK;
                if (st_r.lin_busy) begin
                    // record sensor error per angle bin
                    st_nxt.ang          = st_r.cap_ang;
                    st_nxt.lin[lin_idx] = st_r.cap_ang - angle_in;
                    st_nxt.cap_ang      = cap_next;
                    if (cap_next < st_r.cap_ang) begin
                        if (st_r.cap_rev == LIN_REVS - 3'h1) begin
                            st_nxt.lin_busy  = 1'b0;
                            st_nxt.lin_valid = 1'b1;
                        end else begin
                            st_nxt.cap_rev = st_r.cap_rev + 3'h1;
                        end
                    end
                end else begin
                    st_nxt.corr = (lin_apply_in && st_r.lin_valid) ? st_r.lin[lin_idx] : '0;
                    st_nxt.ang  = angle_in + st_nxt.corr;
                end
            end
            ST_PARK: begin
                st_nxt.id  = fcr_sat16(48'(t_d >>> TRIG_SH));
                st_nxt.iq  = fcr_sat16(48'(t_q >>> TRIG_SH));
                st_nxt.fsm = ST_PI;
            end
            ST_PI: begin
                st_nxt.fsm = ST_PIWAIT;
            end
            ST_PIWAIT: begin
                st_nxt.fsm = ST_IPARK;
            end
            ST_IPARK: begin
                st_nxt.va  = fcr_sat16(48'(t_a >>> TRIG_SH));
                st_nxt.vb  = fcr_sat16(48'(t_b >>> TRIG_SH));
                st_nxt.fsm = ST_DRIVE;
            end
            ST_DRIVE: begin
                st_nxt.drive.u = st_r.va;
                st_nxt.drive.v = fcr_sat16(48'(-half_a) + 48'(t_s >>> TRIG_SH));
                st_nxt.drive.w = fcr_sat16(48'(-half_a) - 48'(t_s >>> TRIG_SH));
                st_nxt.tick    = 1'b1;
                st_nxt.fsm     = ST_IDLE;
            end
            default: begin
                st_nxt.fsm = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            st_r     <= '0;
            st_r.fsm <= ST_IDLE;
            st_r.cnt <= 32'(LOOP_CYCLES - 1);
        end else begin
            st_r <= st_nxt;
        end
    end

    assign drive_out      = st_r.drive;
    assign sense_out      = st_r.sense;
    assign id_out         = st_r.id;
    assign iq_out         = st_r.iq;
    assign elec_angle_out = st_r.ang;
    assign angle_corr_out = st_r.corr;
    assign hall_out       = st_r.hall;
    assign lin_busy_out   = st_r.lin_busy;
    assign lin_valid_out  = st_r.lin_valid;
    assign tick_out       = st_r.tick;

    // Tick spacing watcher, read only by an assertion
    logic [31:0] gap_r;
    logic        seen_r;
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            gap_r  <= '0;
            seen_r <= 1'b0;
        end else begin
            gap_r  <= tick_out ? '0 : gap_r + 32'h1;
            seen_r <= seen_r | tick_out;
        end
    end

    AST_TICK_GAP: assert property (@(posedge clock_in) disable iff (rst_in)
        (tick_out && seen_r) |-> (gap_r == 32'(LOOP_CYCLES - 1)))
        else $error("Loop tick spacing wrong");
    AST_LOOP_SEQ: assert property (@(posedge clock_in) disable iff (rst_in)
        (st_r.fsm == ST_SAMPLE) |-> ##1 (st_r.fsm == ST_PARK) ##1 (st_r.fsm == ST_PI) ##4 tick_out)
        else $error("Loop sequence broken");
    AST_HALL_STATE: assert property (@(posedge clock_in) disable iff (rst_in)
        (st_r.h2 == st_r.h3) |=> (hall_out.state == $past(st_r.h3))
            && (hall_out.state == {hall_out.c, hall_out.b, hall_out.a}))
        else $error("Hall state does not match levels");
    AST_HALL_HOLD: assert property (@(posedge clock_in) disable iff (rst_in)
        (st_r.h2 != st_r.h3) |=> $stable(hall_out))
        else $error("Hall state moved before the pin settled");
    AST_IDREF_ZERO: assert property (@(posedge clock_in) disable iff (rst_in)
        $past(rst_in) |-> (st_r.id_ref == '0))
        else $error("Flux setpoint not zero after reset");
    AST_IDREF_LOAD: assert property (@(posedge clock_in) disable iff (rst_in)
        id_ref_wr_in |=> (st_r.id_ref == $past(id_ref_in)))
        else $error("Flux setpoint not loaded");
    AST_GAIN_IDX: assert property (@(posedge clock_in) disable iff (rst_in)
        gain_wr_in.wr |-> !(ld_kp_d && ld_kp_q) && !(ld_ki_d && ld_ki_q) && (DUAL
            || ((ld_kp_d == (!gain_wr_in.integ && gain_wr_in.idx == 3'h1))
            && (ld_ki_q == (gain_wr_in.integ && gain_wr_in.idx == 3'h2)))))
        else $error("Gain index decode wrong");
    AST_LIN_DONE: assert property (@(posedge clock_in) disable iff (rst_in)
        $fell(lin_busy_out) |-> lin_valid_out && (elec_angle_out == ANG_W'(0) - CAP_STEP))
        else $error("Capture ended without a valid correction");
    AST_SENSE_MON: assert property (@(posedge clock_in) disable iff (rst_in)
        !$past(rst_in) |-> (sense_out == $past(sense_in)))
        else $error("Sense monitor lags");
endmodule : fcr_current_regulator

// File: sim/fcr_motor_model.sv
module fcr_motor_model (
    input  wire fcr_pkg::fcr_phase_t       drive_in,
    input  wire logic [fcr_pkg::ANG_W-1:0] angle_set_in,
    input  wire fcr_pkg::fcr_phase_t       bias_in,
    output fcr_pkg::fcr_phase_t            phase_i_out,
    output logic [fcr_pkg::ANG_W-1:0]      angle_out,
    output logic [2:0]                     hall_out,
    output fcr_pkg::fcr_phase_t            volts_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import fcr_pkg::*;
    // Stiff winding: currents follow the bias only, so loop results stay predictable
    always_comb begin
        phase_i_out = bias_in;
        angle_out   = angle_set_in;
        volts_out   = drive_in;
        // Hall edges spaced one sixth of a turn apart, each sensor a third of a turn behind the last
        hall_out[0] = (angle_set_in < 9'h100);
        hall_out[1] = (angle_set_in >= 9'h0ab) && (angle_set_in < 9'h1ab);
        hall_out[2] = !((angle_set_in >= 9'h055) && (angle_set_in < 9'h155));
    end
endmodule : fcr_motor_model

// File: sim/fcr_current_regulator_bench.sv
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module fcr_current_regulator_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import fcr_pkg::*;
    localparam int LC = 40;
    logic                clock_in = 1'b0;
    logic                rst_in   = 1'b1;
    fcr_phase_t          phase_i, sense, bias, drive_out, sense_out, drive_dual;
    logic [ANG_W-1:0]    angle, ang_set, elec_angle_out, angle_corr_out, a0;
    fcr_sensor_t         sensor = SENS_HALL;
    logic [2:0]          hall;
    logic signed [15:0]  iq_ref = '0, id_ref = '0, id_out, iq_out;
    logic                id_wr = 1'b0, start = 1'b0, apply = 1'b0, clear = 1'b0;
    fcr_gain_wr_t        gain_wr = '0;
    fcr_hall_t           hall_out;
    logic                lin_busy_out, lin_valid_out, tick_out;
    int                  bad_count = 0, checks_done = 0, n;

    always #12.5 clock_in = ~clock_in;
    initial ang_set = '0;
    initial bias = '0;

    fcr_motor_model motor (.drive_in(drive_out), .angle_set_in(ang_set), .bias_in(bias),
        .phase_i_out(phase_i), .angle_out(angle), .hall_out(hall), .volts_out(sense));

    fcr_current_regulator #(.LOOP_CYCLES(LC)) dut (.clock_in(clock_in), .rst_in(rst_in),
        .phase_i_in(phase_i), .angle_in(angle), .sensor_type_in(sensor), .hall_in(hall),
        .iq_ref_in(iq_ref), .id_ref_wr_in(id_wr), .id_ref_in(id_ref), .gain_wr_in(gain_wr),
        .lin_start_in(start), .lin_apply_in(apply), .lin_clear_in(clear), .sense_in(sense),
        .drive_out(drive_out), .sense_out(sense_out), .id_out(id_out), .iq_out(iq_out),
        .elec_angle_out(elec_angle_out), .angle_corr_out(angle_corr_out),
        .hall_out(hall_out), .lin_busy_out(lin_busy_out), .lin_valid_out(lin_valid_out),
        .tick_out(tick_out));

    // Second channel of a dual device, used only to check the gain index map
    fcr_current_regulator #(.LOOP_CYCLES(LC), .DUAL(1'b1), .CHANNEL(2)) dut_dual (.clock_in(clock_in),
        .rst_in(rst_in), .phase_i_in(phase_i), .angle_in(angle), .sensor_type_in(sensor), .hall_in(hall),
        .iq_ref_in(iq_ref), .id_ref_wr_in(id_wr), .id_ref_in(id_ref), .gain_wr_in(gain_wr),
        .lin_start_in(start), .lin_apply_in(apply), .lin_clear_in(clear), .sense_in(sense),
        .drive_out(drive_dual), .sense_out(), .id_out(), .iq_out(), .elec_angle_out(),
        .angle_corr_out(), .hall_out(), .lin_busy_out(), .lin_valid_out(), .tick_out());

    function automatic logic near(input logic signed [15:0] a, input int e);
        logic signed [17:0] d;
        d = 18'(a) - 18'(e);
        near = (d < 18'sd48) && (d > -18'sd48);
    endfunction : near

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    task automatic wait_tick;
        for (n = 0; n < 200; n++) begin
            @(negedge clock_in);
            if (tick_out === 1'b1) break;
        end
        `CHK(n < 200, 1'b1)
    endtask : wait_tick

    task automatic set_gain(input logic integ, input logic [2:0] idx, input logic [31:0] val);
        @(posedge clock_in);
        gain_wr <= '{wr: 1'b1, integ: integ, idx: idx, val: val};
        @(posedge clock_in);
        gain_wr.wr <= 1'b0;
    endtask : set_gain

    task automatic set_flux(input logic signed [15:0] v);
        @(posedge clock_in);
        id_wr  <= 1'b1;
        id_ref <= v;
        @(posedge clock_in);
        id_wr <= 1'b0;
    endtask : set_flux

    task automatic move(input logic [8:0] a, input logic signed [15:0] u, input logic signed [15:0] v);
        @(posedge clock_in);
        ang_set <= a;
        bias    <= '{u: u, v: v, w: -u - v};
        wait_tick();
        wait_tick();
    endtask : move

    task automatic test_reset;
        @(negedge clock_in);
        `CHK(drive_out, 48'h0)
        `CHK(lin_valid_out, 1'b0)
    endtask : test_reset

    task automatic test_period_angle;
        move(9'h1ff, 16'sd0, 16'sd0);
        `CHK(elec_angle_out, 9'h1ff)
        `CHK(angle_corr_out, 9'h000)
        for (n = 1; n < 200; n++) begin
            @(negedge clock_in);
            if (tick_out === 1'b1) break;
        end
        `CHK(n, LC)
    endtask : test_period_angle

    task automatic test_hall_park;
        move(9'h000, 16'sd1000, -16'sd500);
        `CHK(hall_out, 6'h2d)
        `CHK(near(id_out, 1000), 1'b1)
        `CHK(near(iq_out, 0), 1'b1)
        move(9'h080, 16'sd1000, -16'sd500);
        `CHK(hall_out, 6'h0c)
        `CHK(near(id_out, 0), 1'b1)
        `CHK(near(iq_out, -1000), 1'b1)
        move(9'h12c, 16'sd0, 16'sd0);
        `CHK(hall_out, 6'h12)
    endtask : test_hall_park

    task automatic test_pi;
        set_gain(1'b0, 3'h1, 32'd1000000);
        set_gain(1'b0, 3'h2, 32'd2000000);
        set_gain(1'b0, 3'h3, 32'd50000000);
        set_gain(1'b1, 3'h1, 32'd0);
        iq_ref <= 16'sd500;
        move(9'h000, 16'sd1000, -16'sd500);
        `CHK(near(drive_out.u, -1000), 1'b1)
        `CHK(near(drive_out.v, 1366), 1'b1)
        `CHK(near(drive_out.w, -366), 1'b1)
        `CHK(near(sense_out.u, -1000), 1'b1)
        `CHK(near(drive_dual.u, -1998), 1'b1)
        `CHK(near(drive_dual.v, 999), 1'b1)
        set_flux(16'sd1000);
        move(9'h000, 16'sd1000, -16'sd500);
        `CHK(near(drive_out.u, 0), 1'b1)
        set_flux(16'sd0);
        set_gain(1'b0, 3'h1, 32'd100000000);
        move(9'h000, 16'sd1000, -16'sd500);
        `CHK(near(drive_out.u, -32767), 1'b1)
        set_gain(1'b0, 3'h1, 32'd0);
        set_gain(1'b1, 3'h1, 32'd1000000000);
        move(9'h000, 16'sd1000, -16'sd500);
        `CHK(near(drive_out.u, -1998), 1'b1)
        repeat (40) wait_tick();
        `CHK(near(drive_out.u, -32767), 1'b1)
        // Clamped integrator recovers in one step; a wound-up one would stay pinned
        set_flux(16'sd32767);
        wait_tick();
        `CHK(near(drive_out.u, -999), 1'b1)
    endtask : test_pi

    task automatic test_capture;
        @(posedge clock_in);
        start <= 1'b1;
        @(posedge clock_in);
        start <= 1'b0;
        @(negedge clock_in);
        `CHK(lin_busy_out, 1'b0)
        @(posedge clock_in);
        sensor <= SENS_SINCOS;
        start  <= 1'b1;
        @(posedge clock_in);
        start <= 1'b0;
        @(negedge clock_in);
        `CHK(lin_busy_out, 1'b1)
        wait_tick();
        a0 = elec_angle_out;
        wait_tick();
        `CHK(elec_angle_out, a0 + 9'h004)
        for (n = 0; n < LC * 520; n++) begin
            @(negedge clock_in);
            if (lin_busy_out !== 1'b1) break;
        end
        `CHK(lin_valid_out, 1'b1)
        @(posedge clock_in);
        apply <= 1'b1;
        move(9'h000, 16'sd0, 16'sd0);
        `CHK(angle_corr_out, 9'h1fc)
        `CHK(elec_angle_out, 9'h1fc)
        move(9'h020, 16'sd0, 16'sd0);
        `CHK(angle_corr_out, 9'h000)
        `CHK(elec_angle_out, 9'h020)
        @(posedge clock_in);
        apply <= 1'b0;
        clear <= 1'b1;
        @(posedge clock_in);
        clear <= 1'b0;
        @(negedge clock_in);
        `CHK(lin_valid_out, 1'b0)
    endtask : test_capture

    initial begin
        #2ms;
        bad_count++;
        give_verdict();
    end

    initial begin
        repeat (10) @(posedge clock_in);
        rst_in <= 1'b0;
        test_reset();
        test_period_angle();
        test_hall_park();
        test_pi();
        test_capture();
        give_verdict();
    end
endmodule : fcr_current_regulator_bench
